/* dv/mtp_mac_tx_asserts.sv */
`timescale 1ns/1ns
module mtp_mac_tx_asserts
  import mtp_pkg::*;
(
  input wire logic       clock,
  input wire logic       rst_n,
  input wire logic       clock_role_select,
  input wire logic       reduced_iface_select,
  input wire logic       tx_ack,
  input wire logic [3:0] txd,
  input wire logic       tx_en,
  input wire logic       tx_clock_out,
  input wire logic       tx_clock_oe,
  input wire logic       rx_clock_out,
  input wire logic       rx_clock_oe,
  input wire logic       derived_ref_clock_out,
  input wire logic       mdc,
  input wire logic       mdio_out,
  input wire logic       mdio_oe
);
  logic       mdc_q_r;
  logic [7:0] run_r;

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  // cycles spent at the current management clock level
  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n)
    begin
      mdc_q_r <= 1'b0;
      run_r   <= 8'h00;
    end
    else
    begin
      mdc_q_r <= mdc;
      run_r   <= (mdc != mdc_q_r) ? 8'h00 : run_r + 8'h01;
    end

  a_refo_half: assert property (
    $past(rst_n) |-> derived_ref_clock_out != $past(derived_ref_clock_out))
    else $error("reference output not system clock halved");
  a_mdc_rate: assert property ($changed(mdc) |-> run_r >= 8'h1d)
    else $error("management clock too fast");
  a_mdc_bound: assert property (run_r <= 8'h1e)
    else $error("management clock stalled");
  a_mdio_edge: assert property (
    ($changed(mdio_out) || $rose(mdio_oe)) |-> $fell(mdc))
    else $error("management data moved off the falling clock");
  a_ack_once: assert property (tx_ack |=> !tx_ack)
    else $error("byte acknowledge longer than one cycle");
  a_en_preamble: assert property ($rose(tx_en) |-> txd ==
    (reduced_iface_select ? 4'(PREAMBLE_BYTE[1:0]) : PREAMBLE_BYTE[3:0]))
    else $error("enable not raised with first preamble bits");
  a_idle_zero: assert property (!tx_en |-> txd == 4'h0)
    else $error("data moving while enable low");
  a_rmii_pair: assert property (
    reduced_iface_select |-> txd[3:2] == 2'b00)
    else $error("upper data bits used in reduced mode");
  a_role_oe: assert property (
    tx_clock_oe |-> clock_role_select && !reduced_iface_select)
    else $error("clocks driven outside mii dce");
  a_dce_pair: assert property (
    rx_clock_out == tx_clock_out && rx_clock_oe == tx_clock_oe)
    else $error("receive and transmit clocks differ");
endmodule

bind mtp_mac_tx mtp_mac_tx_asserts u_asserts (.clock, .rst_n,
  .clock_role_select, .reduced_iface_select, .tx_ack, .txd, .tx_en,
  .tx_clock_out, .tx_clock_oe, .rx_clock_out, .rx_clock_oe,
  .derived_ref_clock_out, .mdc, .mdio_out, .mdio_oe);

/* dv/mtp_mac_tx_bench.sv */
`timescale 1ns/1ns
module mtp_mac_tx_bench;
  import mtp_pkg::*;

  typedef struct packed {
    logic role;
    logic iface;
    logic speed;
    logic oe;
  } mtp_row_type;

  localparam int          REF_CYC = 10;
  localparam logic [15:0] RD_VAL  = 16'h5ac3;

  logic             clock, rst_n, clock_role_select, reduced_iface_select;
  logic             speed_100_select, tx_valid, tx_last, mgmt_start;
  logic [7:0]       tx_data;
  mtp_mgmt_cmd_type mgmt_cmd;
  wire logic        ref_clock_in, tx_clock_in, phy_mdio;
  logic             tx_ack, tx_en, tx_clock_out, tx_clock_oe, rx_clock_out;
  logic             rx_clock_oe, derived_ref_clock_out, mgmt_busy, mgmt_done;
  logic             mdc, mdio_out, mdio_oe;
  wire logic        mdio_in = mdio_oe ? mdio_out : phy_mdio;
  logic [3:0]       txd;
  logic [15:0]      mgmt_rdata;
  logic [7:0]       exp_q[$];
  int               fail_count, checks_done, per, per_exp;
  mtp_row_type      rows[4] = '{4'b1011, 4'b1001, 4'b0010, 4'b1110};

  mtp_mac_tx DUT (.clock, .rst_n, .clock_role_select, .reduced_iface_select,
    .speed_100_select, .ref_clock_in, .tx_clock_in, .tx_data, .tx_valid,
    .tx_last, .tx_ack, .txd, .tx_en, .tx_clock_out, .tx_clock_oe,
    .rx_clock_out, .rx_clock_oe, .derived_ref_clock_out, .mgmt_start,
    .mgmt_cmd, .mgmt_busy, .mgmt_done, .mgmt_rdata, .mdc, .mdio_in,
    .mdio_out, .mdio_oe);

  mtp_phy_model #(.READ_VALUE(RD_VAL)) u_phy (.rmii(reduced_iface_select),
    .dce(clock_role_select), .dce_clock(tx_clock_out),
    .fast(speed_100_select), .ref_clock(ref_clock_in),
    .tx_clock(tx_clock_in), .txd, .tx_en, .mdc,
    .mdio_oe, .mdio_line(mdio_in), .mdio_drive(phy_mdio));

  // system clock
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic chk(input string what, logic [63:0] seen, logic [63:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    if (fail_count == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // straps applied under reset, then time to settle
  task automatic do_reset(input mtp_row_type r);
    @(negedge clock);
    rst_n = 1'b0;
    {clock_role_select, reduced_iface_select, speed_100_select} = r[3:1];
    repeat (5) @(negedge clock);
    chk("reset", {tx_en, txd, mdc, mdio_oe, mdio_out}, 8'h01);
    rst_n = 1'b1;
    repeat (6) @(negedge clock);
  endtask

  // cycles between two rises of the generated clock
  task automatic clk_period(output int n);
    n = 0;
    for (int lvl = 0; lvl < 4; lvl++)
    begin
      if (lvl == 2)
        n = 0;
      while (tx_clock_out !== lvl[0] && n < 900)
      begin
        @(negedge clock);
        n++;
      end
    end
  endtask

  // each byte held until acknowledged
  task automatic send_frame(input logic [7:0] b[$]);
    int n;
    repeat (PREAMBLE_LEN) exp_q.push_back(PREAMBLE_BYTE);
    exp_q.push_back(SFD_BYTE);
    foreach (b[i])
    begin
      exp_q.push_back(b[i]);
      tx_data  = b[i];
      tx_last  = (i == b.size() - 1);
      tx_valid = 1'b1;
      n = 0;
      do
      begin
        @(negedge clock);
        n++;
      end
      while (tx_ack !== 1'b1 && n < 9000);
      chk("ack", tx_ack, 1'b1);
    end
    tx_valid = 1'b0;
    @(negedge clock);
  endtask

  // far side's bytes against the offered ones
  task automatic rx_compare(input int frames);
    int n;
    n = 0;
    while (tx_en !== 1'b0 && n < 2000)
    begin
      @(negedge clock);
      n++;
    end
    chk("en_low", tx_en, 1'b0);
    chk("frames", u_phy.frames, frames);
    chk("bytes", u_phy.rx_q.size(), exp_q.size());
    foreach (exp_q[i])
      chk("byte", u_phy.rx_q[i], exp_q[i]);
    u_phy.rx_q.delete();
    u_phy.frames = 0;
    exp_q.delete();
  endtask

  // one management frame, up to its done pulse
  task automatic mgmt_op(input logic w, logic [4:0] pa, ra, logic [15:0] wd);
    int n;
    mgmt_cmd   = '{w, pa, ra, wd};
    mgmt_start = 1'b1;
    @(negedge clock);
    mgmt_start = 1'b0;
    chk("md_busy", mgmt_busy, 1'b1);
    n = 0;
    while (mgmt_done !== 1'b1 && n < 9000)
    begin
      @(negedge clock);
      n++;
    end
    chk("md_done", {mgmt_done, mgmt_busy}, 2'b10);
  endtask

  // hang guard
  initial
  begin
    #400_000;
    fail_count++;
    report_and_stop();
  end

  // main sequence
  initial
  begin
    {rst_n, clock_role_select, reduced_iface_select, speed_100_select} = 4'h0;
    {tx_data, tx_valid, tx_last, mgmt_start} = 11'h000;
    mgmt_cmd = '0;
    fail_count = 0;
    checks_done = 0;
    foreach (rows[i])
    begin
      do_reset(rows[i]);
      chk("clk_oe", tx_clock_oe, rows[i].oe);
      if (rows[i].oe)
      begin
        clk_period(per);
        per_exp = 2 * REF_CYC *
                  (rows[i].speed ? DCE_HALF_FAST : DCE_HALF_SLOW);
        chk("clk_per", per, per_exp);
      end
    end
    do_reset(4'b0010);
    send_frame('{8'ha1, 8'h3c});
    send_frame('{8'h00, 8'hff, 8'h7e});
    rx_compare(2);
    do_reset(4'b0110);
    send_frame('{8'hc5, 8'h1e});
    rx_compare(1);
    // mii dce frame, then rmii 10 Mbps frame
    do_reset(4'b1011);
    send_frame('{8'h96});
    rx_compare(1);
    do_reset(4'b0100);
    send_frame('{8'h3a});
    rx_compare(1);
    mgmt_op(1'b1, 5'h00, 5'h00, 16'h1200);
    chk("md_wr", u_phy.shift_r, {MD_PREAMBLE, MD_START, MD_OP_WRITE,
        10'h000, MD_TA_WRITE, 16'h1200});
    mgmt_op(1'b0, 5'h1f, 5'h1f, 16'h0000);
    chk("md_rdh", u_phy.shift_r[45:0], {MD_PREAMBLE, 4'h6, 10'h3ff});
    chk("md_rd", mgmt_rdata, RD_VAL);
    report_and_stop();
  end
endmodule

/* dv/mtp_phy_model.sv */
`timescale 1ns/1ns
module mtp_phy_model
#(
  parameter logic [15:0] READ_VALUE = 16'h0000
)
(
  input  wire logic       rmii,
  input  wire logic       dce,
  input  wire logic       dce_clock,
  input  wire logic       fast,
  output logic            ref_clock,
  output logic            tx_clock,
  input  wire logic [3:0] txd,
  input  wire logic       tx_en,
  input  wire logic       mdc,
  input  wire logic       mdio_oe,
  input  wire logic       mdio_line,
  output logic            mdio_drive
);
  logic [7:0]  rx_q[$];
  logic [7:0]  byte_r;
  logic [2:0]  fill = 3'h0;
  logic        en_q = 1'b0;
  int          frames = 0;
  int          skip = 0;
  logic [63:0] shift_r;
  logic [6:0]  drv_n = 7'h0;
  logic [5:0]  rel_n = 6'h3f;
  // dce: the device's clock, taken mid-period on its falling edge
  wire logic   smp = rmii ? ref_clock : (dce ? !dce_clock : tx_clock);

  // free-running reference and transmit clocks
  initial
  begin
    ref_clock = 1'b0;
    forever #50 ref_clock = ~ref_clock;
  end
  initial
  begin
    tx_clock = 1'b0;
    forever #40 tx_clock = ~tx_clock;
  end

  // gather nibbles or dibits into bytes, low part first;
  // rmii 10 Mbps takes one dibit per ten reference periods
  always @(posedge smp)
  begin
    if (tx_en && !en_q)
    begin
      frames++;
      skip = 0;
    end
    en_q = tx_en;
    if (skip != 0)
      skip--;
    else
    begin
      skip = (rmii && !fast) ? mtp_pkg::RMII_SLOW_REP - 1 : 0;
      if (!tx_en)
        fill = 3'h0;
      else if (rmii)
        {byte_r, fill} = {txd[1:0], byte_r[7:2], fill + 3'h2};
      else
        {byte_r, fill} = {txd, byte_r[7:4], fill + 3'h4};
      if (tx_en && fill == 3'h0)
        rx_q.push_back(byte_r);
    end
  end

  // record driven bits, count released ones
  always @(posedge mdc)
  begin
    if (mdio_oe)
    begin
      drv_n   <= (rel_n != 6'h0) ? 7'h1 : drv_n + 7'h1;
      rel_n   <= 6'h0;
      shift_r <= {shift_r[62:0], mdio_line};
    end
    else if (rel_n != 6'h3f)
      rel_n <= rel_n + 6'h1;
  end

  // read data after a 46-bit header, else the pull-up shows
  assign mdio_drive = (drv_n == 7'd46 && rel_n >= 6'd2 && rel_n <= 6'd17)
    ? READ_VALUE[6'd17 - rel_n] : 1'b1;
endmodule

/* rtl/mtp_mac_tx.sv */
`timescale 1ns/1ns
module mtp_mac_tx
(
  input  wire logic                      clock,
  input  wire logic                      rst_n,
  input  wire logic                      clock_role_select,
  input  wire logic                      reduced_iface_select,
  input  wire logic                      speed_100_select,
  input  wire logic                      ref_clock_in,
  input  wire logic                      tx_clock_in,
  input  wire logic [7:0]                tx_data,
  input  wire logic                      tx_valid,
  input  wire logic                      tx_last,
  output logic                           tx_ack,
  output logic [3:0]                     txd,
  output logic                           tx_en,
  output logic                           tx_clock_out,
  output logic                           tx_clock_oe,
  output logic                           rx_clock_out,
  output logic                           rx_clock_oe,
  output logic                           derived_ref_clock_out,
  input  wire logic                      mgmt_start,
  input  wire mtp_pkg::mtp_mgmt_cmd_type mgmt_cmd,
  output logic                           mgmt_busy,
  output logic                           mgmt_done,
  output logic [15:0]                    mgmt_rdata,
  output logic                           mdc,
  input  wire logic                      mdio_in,
  output logic                           mdio_out,
  output logic                           mdio_oe
);
  import mtp_pkg::*;

  logic [PIN_COUNT-1:0] pins;
  logic [PIN_COUNT-1:0] s1_r;
  logic [PIN_COUNT-1:0] s2_r;
  logic [PIN_COUNT-1:0] s3_r;
  logic [PIN_COUNT-1:0] filt_r;
  logic [PIN_COUNT-1:0] filt_nxt;

  logic                 dce_mode;
  logic                 rmii;
  logic                 fast;
  logic                 ref_rise;
  logic                 txclk_rise;

  logic [3:0]           dce_cnt_r, dce_cnt_nxt;
  logic                 dce_clk_r, dce_clk_nxt;
  logic                 dce_oe_r,  dce_oe_nxt;
  logic                 dce_rise;
  logic [3:0]           dce_half;

  logic                 refo_r,    refo_nxt;
  logic [3:0]           refo_cnt_r, refo_cnt_nxt;

  logic [3:0]           rep_r,     rep_nxt;
  logic                 base_tick;
  logic                 tick;

  mtp_tx_state_type     st_r,      st_nxt;
  logic [7:0]           sh_r,      sh_nxt;
  logic [1:0]           sub_r,     sub_nxt;
  logic [2:0]           pcnt_r,    pcnt_nxt;
  logic [5:0]           gap_r,     gap_nxt;
  logic                 last_r,    last_nxt;
  logic [3:0]           txd_r,     txd_nxt;
  logic                 en_r,      en_nxt;
  logic                 ack_r,     ack_nxt;
  logic [1:0]           unit_last;
  logic [5:0]           gap_last;

  assign pins = {mdio_in, tx_clock_in, ref_clock_in, speed_100_select,
                 reduced_iface_select, clock_role_select};

  // pin synchronisers, a level counts once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < PIN_COUNT; gi++)
    begin : g_sync
      assign filt_nxt[gi] = (s2_r[gi] == s3_r[gi]) ? s3_r[gi] : filt_r[gi];
    end
  endgenerate

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_r   <= '0;
      s2_r   <= '0;
      s3_r   <= '0;
      filt_r <= '0;
    end
    else
    begin
      s1_r   <= pins;
      s2_r   <= s1_r;
      s3_r   <= s2_r;
      filt_r <= filt_nxt;
    end
  end

  // strap decode
  always_comb
  begin
    rmii       = filt_r[PIN_IFACE];
    dce_mode   = filt_r[PIN_ROLE] && !rmii;
    fast       = filt_r[PIN_SPEED];
    ref_rise   = filt_nxt[PIN_REFCLK] && !filt_r[PIN_REFCLK];
    txclk_rise = filt_nxt[PIN_TXCLK] && !filt_r[PIN_TXCLK];
    dce_half   = fast ? 4'(DCE_HALF_FAST) : 4'(DCE_HALF_SLOW);
    dce_rise   = dce_mode && ref_rise && !dce_clk_r &&
                 (dce_cnt_r == dce_half - 4'h1);
  end

  // dce clock generation from reference edges, plus derived ref clock
  always_comb
  begin
    dce_cnt_nxt  = dce_cnt_r;
    dce_clk_nxt  = dce_clk_r;
    dce_oe_nxt   = dce_mode;
    if (!dce_mode)
    begin
      dce_cnt_nxt = 4'h0;
      dce_clk_nxt = 1'b0;
    end
    else if (ref_rise)
    begin
      if (dce_cnt_r >= dce_half - 4'h1)
      begin
        dce_cnt_nxt = 4'h0;
        dce_clk_nxt = ~dce_clk_r;
      end
      else
        dce_cnt_nxt = dce_cnt_r + 4'h1;
    end
    if (refo_cnt_r == 4'(REFO_HALF_CYC - 1))
    begin
      refo_cnt_nxt = 4'h0;
      refo_nxt     = ~refo_r;
    end
    else
    begin
      refo_cnt_nxt = refo_cnt_r + 4'h1;
      refo_nxt     = refo_r;
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dce_cnt_r  <= 4'h0;
      dce_clk_r  <= 1'b0;
      dce_oe_r   <= 1'b0;
      refo_cnt_r <= 4'h0;
      refo_r     <= 1'b0;
    end
    else
    begin
      dce_cnt_r  <= dce_cnt_nxt;
      dce_clk_r  <= dce_clk_nxt;
      dce_oe_r   <= dce_oe_nxt;
      refo_cnt_r <= refo_cnt_nxt;
      refo_r     <= refo_nxt;
    end
  end

  // transmit tick selection and rmii slow repeat
  always_comb
  begin
    if (rmii)
      base_tick = ref_rise;
    else if (dce_mode)
      base_tick = dce_rise;
    else
      base_tick = txclk_rise;
    rep_nxt = rep_r;
    if (!rmii || fast)
      rep_nxt = 4'h0;
    else if (base_tick)
      rep_nxt = (rep_r == 4'(RMII_SLOW_REP - 1)) ? 4'h0 : rep_r + 4'h1;
    tick = base_tick && (rep_r == 4'h0);
  end

  // frame sequencer: preamble, sfd, user bytes, interframe gap
  always_comb
  begin
    unit_last = rmii ? RMII_UNIT_LAST : MII_UNIT_LAST;
    gap_last  = rmii ? RMII_GAP_LAST : MII_GAP_LAST;
    st_nxt    = st_r;
    sh_nxt    = sh_r;
    sub_nxt   = sub_r;
    pcnt_nxt  = pcnt_r;
    gap_nxt   = gap_r;
    last_nxt  = last_r;
    txd_nxt   = txd_r;
    en_nxt    = en_r;
    ack_nxt   = 1'b0;
    unique case (st_r)
      TX_IDLE:
      begin
        if (tx_valid)
        begin
          st_nxt   = TX_PRE;
          sh_nxt   = PREAMBLE_BYTE;
          sub_nxt  = 2'h0;
          pcnt_nxt = 3'h0;
        end
      end
      TX_GAP:
      begin
        if (tick)
        begin
          en_nxt  = 1'b0;
          txd_nxt = 4'h0;
          gap_nxt = gap_r + 6'h1;
          if (gap_r == gap_last)
            st_nxt = TX_IDLE;
        end
      end
      TX_PRE, TX_DATA:
      begin
        if (tick)
        begin
          en_nxt = 1'b1;
          if (rmii)
          begin
            txd_nxt = {2'b00, sh_r[1:0]};
            sh_nxt  = {2'b00, sh_r[7:2]};
          end
          else
          begin
            txd_nxt = sh_r[3:0];
            sh_nxt  = {4'h0, sh_r[7:4]};
          end
          sub_nxt = sub_r + 2'h1;
          if (sub_r == unit_last)
          begin
            sub_nxt = 2'h0;
            if (st_r == TX_PRE && pcnt_r < PREAMBLE_LEN)
            begin
              pcnt_nxt = pcnt_r + 3'h1;
              sh_nxt   = (pcnt_r == PREAMBLE_LEN - 3'h1) ?
                         SFD_BYTE : PREAMBLE_BYTE;
            end
            else if ((st_r == TX_DATA && last_r) || !tx_valid)
            begin
              st_nxt  = TX_GAP;
              gap_nxt = 6'h0;
            end
            else
            begin
              st_nxt   = TX_DATA;
              sh_nxt   = tx_data;
              last_nxt = tx_last;
              ack_nxt  = 1'b1;
            end
          end
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rep_r  <= 4'h0;
      st_r   <= TX_IDLE;
      sh_r   <= 8'h0;
      sub_r  <= 2'h0;
      pcnt_r <= 3'h0;
      gap_r  <= 6'h0;
      last_r <= 1'b0;
      txd_r  <= 4'h0;
      en_r   <= 1'b0;
      ack_r  <= 1'b0;
    end
    else
    begin
      rep_r  <= rep_nxt;
      st_r   <= st_nxt;
      sh_r   <= sh_nxt;
      sub_r  <= sub_nxt;
      pcnt_r <= pcnt_nxt;
      gap_r  <= gap_nxt;
      last_r <= last_nxt;
      txd_r  <= txd_nxt;
      en_r   <= en_nxt;
      ack_r  <= ack_nxt;
    end
  end

  // management port
  mtp_mgmt u_mgmt
  (
    .clock      (clock),
    .rst_n      (rst_n),
    .start      (mgmt_start),
    .cmd        (mgmt_cmd),
    .mdio_level (filt_r[PIN_MDIO]),
    .busy       (mgmt_busy),
    .done       (mgmt_done),
    .rdata      (mgmt_rdata),
    .mdc        (mdc),
    .mdio_out   (mdio_out),
    .mdio_oe    (mdio_oe)
  );

  // outputs straight from flip-flops
  assign tx_ack                = ack_r;
  assign txd                   = txd_r;
  assign tx_en                 = en_r;
  assign tx_clock_out          = dce_clk_r;
  assign rx_clock_out          = dce_clk_r;
  assign tx_clock_oe           = dce_oe_r;
  assign rx_clock_oe           = dce_oe_r;
  assign derived_ref_clock_out = refo_r;

endmodule

/* rtl/mtp_mgmt.sv */
`timescale 1ns/1ns
module mtp_mgmt
(
  input  wire logic                      clock,
  input  wire logic                      rst_n,
  input  wire logic                      start,
  input  wire mtp_pkg::mtp_mgmt_cmd_type cmd,
  input  wire logic                      mdio_level,
  output logic                           busy,
  output logic                           done,
  output logic [15:0]                    rdata,
  output logic                           mdc,
  output logic                           mdio_out,
  output logic                           mdio_oe
);
  import mtp_pkg::*;

  logic [5:0]  div_r,   div_nxt;
  logic        mdc_r,   mdc_nxt;
  logic        pend_r,  pend_nxt;
  logic        run_r,   run_nxt;
  logic        wr_r,    wr_nxt;
  logic [5:0]  bit_r,   bit_nxt;
  logic [63:0] sh_r,    sh_nxt;
  logic        out_r,   out_nxt;
  logic        oe_r,    oe_nxt;
  logic        done_r,  done_nxt;
  logic [15:0] rd_r,    rd_nxt;
  logic        hit;

  // clock divider, bits change on falling edges, sampled on rising
  always_comb
  begin
    hit      = (div_r == 6'(MDC_HALF_CYC - 1));
    div_nxt  = hit ? 6'h0 : div_r + 6'h1;
    mdc_nxt  = hit ? ~mdc_r : mdc_r;
    pend_nxt = pend_r | start;
    run_nxt  = run_r;
    wr_nxt   = wr_r;
    bit_nxt  = bit_r;
    sh_nxt   = sh_r;
    out_nxt  = out_r;
    oe_nxt   = oe_r;
    done_nxt = 1'b0;
    rd_nxt   = rd_r;
    if (hit && mdc_r)
    begin
      if (run_r)
      begin
        if (bit_r == MD_LAST_BIT)
        begin
          run_nxt  = 1'b0;
          oe_nxt   = 1'b0;
          out_nxt  = 1'b1;
          done_nxt = 1'b1;
        end
        else
        begin
          bit_nxt = bit_r + 6'h1;
          out_nxt = sh_r[63];
          sh_nxt  = {sh_r[62:0], 1'b0};
          oe_nxt  = wr_r || (bit_r + 6'h1 < MD_DRIVE_BITS);
        end
      end
      else if (pend_r)
      begin
        // any of 32 phys, any of 32 registers, read or write
        sh_nxt   = {MD_PREAMBLE, MD_START,
                    cmd.write ? MD_OP_WRITE : MD_OP_READ,
                    cmd.phy_addr, cmd.reg_addr,
                    cmd.write ? MD_TA_WRITE : MD_TA_READ,
                    cmd.wdata} << 1;
        out_nxt  = MD_PREAMBLE[31];
        oe_nxt   = 1'b1;
        wr_nxt   = cmd.write;
        bit_nxt  = 6'h0;
        run_nxt  = 1'b1;
        pend_nxt = 1'b0;
      end
    end
    // read data is sampled on the rising edge
    if (hit && !mdc_r && run_r && !wr_r && bit_r >= MD_DATA_FIRST)
      rd_nxt = {rd_r[14:0], mdio_level};
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div_r  <= 6'h0;
      mdc_r  <= 1'b0;
      pend_r <= 1'b0;
      run_r  <= 1'b0;
      wr_r   <= 1'b0;
      bit_r  <= 6'h0;
      sh_r   <= 64'h0;
      out_r  <= 1'b1;
      oe_r   <= 1'b0;
      done_r <= 1'b0;
      rd_r   <= 16'h0;
    end
    else
    begin
      div_r  <= div_nxt;
      mdc_r  <= mdc_nxt;
      pend_r <= pend_nxt;
      run_r  <= run_nxt;
      wr_r   <= wr_nxt;
      bit_r  <= bit_nxt;
      sh_r   <= sh_nxt;
      out_r  <= out_nxt;
      oe_r   <= oe_nxt;
      done_r <= done_nxt;
      rd_r   <= rd_nxt;
    end
  end

  assign busy     = pend_r | run_r;
  assign done     = done_r;
  assign rdata    = rd_r;
  assign mdc      = mdc_r;
  assign mdio_out = out_r;
  assign mdio_oe  = oe_r;

endmodule

/* rtl/mtp_pkg.sv */
package mtp_pkg;

  // system clock rate
  localparam int unsigned CLK_HZ         = 100_000_000;

  // derived reference clock, at most 50 MHz
  localparam int unsigned REFO_MAX_HZ    = 50_000_000;
  localparam int unsigned REFO_HALF_CYC  =
    (CLK_HZ + 2 * REFO_MAX_HZ - 1) / (2 * REFO_MAX_HZ);

  // management clock, at most 1.67 MHz (rounded up half period)
  localparam int unsigned MDC_MAX_HZ     = 1_670_000;
  localparam int unsigned MDC_HALF_CYC   =
    (CLK_HZ + 2 * MDC_MAX_HZ - 1) / (2 * MDC_MAX_HZ);

  // dce clock generation: reference rising edges per half period
  localparam int unsigned DCE_HALF_FAST  = 1;
  localparam int unsigned DCE_HALF_SLOW  = 10;

  // rmii 10 Mbps: reference periods per dibit
  localparam int unsigned RMII_SLOW_REP  = 10;

  // frame framing
  localparam logic [7:0]  PREAMBLE_BYTE  = 8'h55;
  localparam logic [7:0]  SFD_BYTE       = 8'hd5;
  localparam logic [2:0]  PREAMBLE_LEN   = 3'h7;
  localparam int unsigned IPG_BYTES      = 12;
  localparam logic [1:0]  MII_UNIT_LAST  = 2'h1;
  localparam logic [1:0]  RMII_UNIT_LAST = 2'h3;
  localparam logic [5:0]  MII_GAP_LAST   = 6'(IPG_BYTES * 2 - 1);
  localparam logic [5:0]  RMII_GAP_LAST  = 6'(IPG_BYTES * 4 - 1);

  // pin synchroniser slots
  localparam int unsigned PIN_ROLE       = 0;
  localparam int unsigned PIN_IFACE      = 1;
  localparam int unsigned PIN_SPEED      = 2;
  localparam int unsigned PIN_REFCLK     = 3;
  localparam int unsigned PIN_TXCLK      = 4;
  localparam int unsigned PIN_MDIO       = 5;
  localparam int unsigned PIN_COUNT      = 6;

  // management frame layout, sent msb first
  localparam logic [31:0] MD_PREAMBLE    = 32'hffff_ffff;
  localparam logic [1:0]  MD_START       = 2'h1;
  localparam logic [1:0]  MD_OP_WRITE    = 2'h1;
  localparam logic [1:0]  MD_OP_READ     = 2'h2;
  localparam logic [1:0]  MD_TA_WRITE    = 2'h2;
  localparam logic [1:0]  MD_TA_READ     = 2'h0;
  localparam logic [5:0]  MD_LAST_BIT    = 6'h3f;
  localparam logic [5:0]  MD_DRIVE_BITS  = 6'h2e;
  localparam logic [5:0]  MD_DATA_FIRST  = 6'h30;

  typedef struct packed {
    logic        write;
    logic [4:0]  phy_addr;
    logic [4:0]  reg_addr;
    logic [15:0] wdata;
  } mtp_mgmt_cmd_type;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_PRE  = 2'b01,
    TX_DATA = 2'b10,
    TX_GAP  = 2'b11
  } mtp_tx_state_type;

endpackage
